// File: xcr_regs.vh
// Offsets, field positions, reset values and scale figures of the config registers 3 to 5.
`ifndef XCR_REGS_VH
`define XCR_REGS_VH

`define XCR_ADDR_W 4
`define XCR_OFS_RF_COARSE 4'h2
`define XCR_OFS_MOD_SLEEP 4'h3
`define XCR_OFS_CHECK_BIT_COUNT_LIM 4'h4

`define XCR_RST_RF_COARSE 8'h0b
`define XCR_RST_MOD_SLEEP 8'h28
`define XCR_RST_CHECK_BIT_COUNT_LIM 8'h50

`define XCR_B_CLK_OUT_EN 0
`define XCR_B_EXT_SUPPLY_EN 1
`define XCR_B_COARSE_LO 2
`define XCR_B_COARSE_HI 3
`define XCR_B_LIMIT_EXTEND 0
`define XCR_B_POLL_EXTEND 1
`define XCR_B_SLEEP_LSB 2
`define XCR_B_SLEEP_MSB 6
`define XCR_B_MODULATION 7
`define XCR_B_MIN_LIM_LSB 0
`define XCR_B_MIN_LIM_MSB 5
`define XCR_B_CHECK_LSB 6
`define XCR_B_CHECK_MSB 7
`define XCR_RF_COARSE_MASK 8'h0f

`define XCR_COARSE_STEP 9'h080
`define XCR_SLEEP_UNIT_SHIFT 10
`define XCR_POLL_EXT_SHIFT 3
`define XCR_CHECK_STEP 4'h3

`define XCR_OPM_RX_POLL 2'h2
`define XCR_OPM_RX 2'h3

`endif

// File: xcr_sync2.v
// Two-stage synchroniser for a bus of asynchronous levels.
`timescale 1ns/1ns
`default_nettype none
module xcr_sync2 #(
   parameter WIDTH = 5,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst_b,
   // Levels
   input wire [WIDTH-1:0] i_async,
   output reg [WIDTH-1:0] o_sync
);

   reg [WIDTH-1:0] meta_r;

   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_r <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end

endmodule
`default_nettype wire

// File: xcr_cfg_regs.v
// Configuration registers 3 to 5: RF coarse tune, supply and clock enables, modulation, timing.
//
// Contract
// - Coarse code 00..11 gives term 0, 128, 256, 384; reset code 10.
// - Supply enable 0 switches external supply output off, 1 on; reset 1.
// - Bit-check ok in RX modes, key event or wake flag forces both enables to 1.
// - Clock output enable gates the clock output pin; reset 1.
// - Register 4 bit 7 selects FSK at 0 (reset) or ASK at 1.
// - Sleep field bits 6..2 gives sleep = value x 1024 x extension; reset 10.
// - Sleep extension bit gives factor 1 at 0 (reset) or 8 at 1.
// - Limit extension bit gives factor 1 at 0 (reset) or 2 at 1.
// - Bit-check code 00..11 checks 0, 3, 6 or 9 bits; reset 3.
// - RX minimum edge time = field x extended period; below 10 unsupported; reset 16.
// - TX baud = 1 / (2 x (field+1) x extended period); reset 16.
// - Extended period = 8, 4, 2 or 1 data clocks x limit factor.
// - Seven-bit fine term forms low part of nine-bit RF word.
// - Wake-up by pin, key or auxiliary supply restores all defaults.
`timescale 1ns/1ns
`default_nettype none
`include "xcr_regs.vh"
module xcr_cfg_regs #(
   parameter KEYS = 5
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst_b,
   // Register access from the serial interface front end
   input wire i_wr_en,
   input wire i_rd_en,
   input wire [`XCR_ADDR_W-1:0] i_addr,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   // Device context
   input wire [1:0] i_opm,
   input wire i_check_bit_count_ok,
   input wire i_wake_flag,
   input wire i_wake_reinit,
   input wire [KEYS-1:0] i_key_input_b,
   input wire [6:0] i_fine_freq_term,
   input wire [1:0] i_baud_range_select,
   // Controls to the analog and timing logic
   output reg o_ext_supply_enable,
   output reg o_clk_out_en,
   output reg o_clk_out,
   output reg [8:0] o_coarse_freq_term,
   output reg [8:0] o_tune_word,
   output reg o_modulation_select,
   output reg [17:0] o_sleep_dclk,
   output reg [1:0] o_limit_factor,
   output reg [3:0] o_check_bit_count,
   output reg [4:0] o_ext_data_clock_period,
   output reg [9:0] o_min_edge_dclk,
   output reg [10:0] o_tx_half_bit_dclk
);

   //--------------------------------------------------------------------
   // Key input synchronisation and event detection
   //--------------------------------------------------------------------
   wire [KEYS-1:0] key_sync;
   reg [KEYS-1:0] key_prev_r;
   wire key_event;

   xcr_sync2 #(
      .WIDTH(KEYS),
      .RST_VAL({KEYS{1'b1}})
   ) u_key_sync (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_async(i_key_input_b),
      .o_sync(key_sync)
   );

   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         key_prev_r <= {KEYS{1'b1}};
      end else begin
         key_prev_r <= key_sync;
      end
   end

   assign key_event = |(key_sync ^ key_prev_r);

   //--------------------------------------------------------------------
   // Register file
   //--------------------------------------------------------------------
   reg [7:0] rf_coarse_supply_clock_ctrl_r;
   reg [7:0] modulation_sleep_limit_ctrl_r;
   reg [7:0] bitcheck_min_limit_ctrl_r;
   reg [7:0] rf_coarse_nxt;
   reg [7:0] mod_sleep_nxt;
   reg [7:0] check_bit_count_lim_nxt;
   wire rx_mode;
   wire force_on;

   assign rx_mode = (i_opm == `XCR_OPM_RX) || (i_opm == `XCR_OPM_RX_POLL);
   assign force_on = (i_check_bit_count_ok && rx_mode) || key_event || i_wake_flag;

   always @* begin
      rf_coarse_nxt = rf_coarse_supply_clock_ctrl_r;
      mod_sleep_nxt = modulation_sleep_limit_ctrl_r;
      check_bit_count_lim_nxt = bitcheck_min_limit_ctrl_r;
      if (i_wake_reinit) begin
         rf_coarse_nxt = `XCR_RST_RF_COARSE;
         mod_sleep_nxt = `XCR_RST_MOD_SLEEP;
         check_bit_count_lim_nxt = `XCR_RST_CHECK_BIT_COUNT_LIM;
      end else if (i_wr_en) begin
         case (i_addr)
            `XCR_OFS_RF_COARSE: begin
               rf_coarse_nxt = i_wdata & `XCR_RF_COARSE_MASK;
            end
            `XCR_OFS_MOD_SLEEP: begin
               mod_sleep_nxt = i_wdata;
            end
            `XCR_OFS_CHECK_BIT_COUNT_LIM: begin
               check_bit_count_lim_nxt = i_wdata;
            end
            default: begin
               rf_coarse_nxt = rf_coarse_supply_clock_ctrl_r;
            end
         endcase
      end
      // Hardware set wins over a simultaneous software clear.
      if (force_on) begin
         rf_coarse_nxt[`XCR_B_EXT_SUPPLY_EN] = 1'b1;
         rf_coarse_nxt[`XCR_B_CLK_OUT_EN] = 1'b1;
      end
   end

   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rf_coarse_supply_clock_ctrl_r <= `XCR_RST_RF_COARSE;
         modulation_sleep_limit_ctrl_r <= `XCR_RST_MOD_SLEEP;
         bitcheck_min_limit_ctrl_r <= `XCR_RST_CHECK_BIT_COUNT_LIM;
      end else begin
         rf_coarse_supply_clock_ctrl_r <= rf_coarse_nxt;
         modulation_sleep_limit_ctrl_r <= mod_sleep_nxt;
         bitcheck_min_limit_ctrl_r <= check_bit_count_lim_nxt;
      end
   end

   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata <= 8'h00;
      end else if (i_rd_en) begin
         case (i_addr)
            `XCR_OFS_RF_COARSE: begin
               o_rdata <= rf_coarse_supply_clock_ctrl_r;
            end
            `XCR_OFS_MOD_SLEEP: begin
               o_rdata <= modulation_sleep_limit_ctrl_r;
            end
            `XCR_OFS_CHECK_BIT_COUNT_LIM: begin
               o_rdata <= bitcheck_min_limit_ctrl_r;
            end
            default: begin
               o_rdata <= 8'h00;
            end
         endcase
      end
   end

   //--------------------------------------------------------------------
   // Field decode
   //--------------------------------------------------------------------
   wire [1:0] coarse_code;
   wire [4:0] sleep_val;
   wire poll_interval_extend;
   wire limit_window_extend;
   wire [1:0] check_code;
   wire [5:0] min_lim;
   reg [8:0] coarse_nxt;
   reg [17:0] sleep_nxt;
   reg [1:0] limit_nxt;
   reg [4:0] xdclk_nxt;

   assign coarse_code = {rf_coarse_supply_clock_ctrl_r[`XCR_B_COARSE_HI],
                         rf_coarse_supply_clock_ctrl_r[`XCR_B_COARSE_LO]};
   assign sleep_val = modulation_sleep_limit_ctrl_r[`XCR_B_SLEEP_MSB:`XCR_B_SLEEP_LSB];
   assign poll_interval_extend = modulation_sleep_limit_ctrl_r[`XCR_B_POLL_EXTEND];
   assign limit_window_extend = modulation_sleep_limit_ctrl_r[`XCR_B_LIMIT_EXTEND];
   assign check_code = bitcheck_min_limit_ctrl_r[`XCR_B_CHECK_MSB:`XCR_B_CHECK_LSB];
   assign min_lim = bitcheck_min_limit_ctrl_r[`XCR_B_MIN_LIM_MSB:`XCR_B_MIN_LIM_LSB];

   always @* begin
      coarse_nxt = {7'h00, coarse_code} * `XCR_COARSE_STEP;
      sleep_nxt = {13'h0000, sleep_val} << `XCR_SLEEP_UNIT_SHIFT;
      if (poll_interval_extend) begin
         sleep_nxt = sleep_nxt << `XCR_POLL_EXT_SHIFT;
      end
      limit_nxt = limit_window_extend ? 2'h2 : 2'h1;
      case (i_baud_range_select)
         2'h0: xdclk_nxt = 5'h08;
         2'h1: xdclk_nxt = 5'h04;
         2'h2: xdclk_nxt = 5'h02;
         default: xdclk_nxt = 5'h01;
      endcase
      if (limit_window_extend) begin
         xdclk_nxt = xdclk_nxt << 1;
      end
   end

   //--------------------------------------------------------------------
   // Registered outputs
   //--------------------------------------------------------------------
   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_ext_supply_enable <= 1'b1;
         o_clk_out_en <= 1'b1;
         o_clk_out <= 1'b0;
         o_coarse_freq_term <= 9'h100;
         o_tune_word <= 9'h100;
         o_modulation_select <= 1'b0;
         o_sleep_dclk <= 18'h02800;
         o_limit_factor <= 2'h1;
         o_check_bit_count <= 4'h3;
         o_ext_data_clock_period <= 5'h02;
         o_min_edge_dclk <= 10'h020;
         o_tx_half_bit_dclk <= 11'h022;
      end else begin
         o_ext_supply_enable <= rf_coarse_supply_clock_ctrl_r[`XCR_B_EXT_SUPPLY_EN];
         o_clk_out_en <= rf_coarse_supply_clock_ctrl_r[`XCR_B_CLK_OUT_EN];
         // The output clock stops low when disabled.
         o_clk_out <= o_clk_out_en ? ~o_clk_out : 1'b0;
         o_coarse_freq_term <= coarse_nxt;
         o_tune_word <= coarse_nxt + {2'h0, i_fine_freq_term};
         o_modulation_select <= modulation_sleep_limit_ctrl_r[`XCR_B_MODULATION];
         o_sleep_dclk <= sleep_nxt;
         o_limit_factor <= limit_nxt;
         o_check_bit_count <= {2'h0, check_code} * `XCR_CHECK_STEP;
         o_ext_data_clock_period <= xdclk_nxt;
         o_min_edge_dclk <= {4'h0, min_lim} * {5'h00, xdclk_nxt};
         o_tx_half_bit_dclk <= ({5'h00, min_lim} + 11'h001) * {6'h00, xdclk_nxt};
      end
   end

endmodule
`default_nettype wire

// File: xcr_host_model.sv
// Host microcontroller model driving the register strobes.
`timescale 1ns/1ns
`default_nettype none
`include "xcr_regs.vh"
module xcr_host_model (
   // Clock and mode
   input wire logic i_mclk,
   input wire logic i_aux,
   // Register bus
   input wire logic [7:0] i_rdata,
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [3:0] o_addr,
   output logic [7:0] o_wdata
);
   initial {o_wr_en, o_rd_en, o_addr, o_wdata} = 14'h0;
   // Released lines show the inverse so a stale value is never mistaken for data.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      o_wr_en <= 1'b1;
      o_addr <= a;
      o_wdata <= (i_aux && a == `XCR_OFS_RF_COARSE) ? (d | 8'h02) : d;
      @(posedge i_mclk);
      o_wr_en <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      o_rd_en <= 1'b1;
      o_addr <= a;
      @(posedge i_mclk);
      o_rd_en <= 1'b0;
      o_addr <= ~a;
      @(posedge i_mclk);
      d = i_rdata;
   endtask
endmodule
`default_nettype wire

// File: xcr_cfg_regs_asserts.sv
// Checker for the config register outputs.
`timescale 1ns/1ns
`default_nettype none
module xcr_cfg_regs_asserts (
   input wire i_mclk,
   input wire i_rst_b,
   input wire [1:0] i_opm,
   input wire i_check_bit_count_ok,
   input wire i_wake_flag,
   input wire o_ext_supply_enable,
   input wire o_clk_out_en,
   input wire o_clk_out,
   input wire [8:0] o_coarse_freq_term,
   input wire [17:0] o_sleep_dclk,
   input wire [1:0] o_limit_factor,
   input wire [3:0] o_check_bit_count,
   input wire [4:0] o_ext_data_clock_period,
   input wire [9:0] o_min_edge_dclk,
   input wire [10:0] o_tx_half_bit_dclk
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   sequence s_en_on; o_ext_supply_enable && o_clk_out_en; endsequence
   sequence s_off3; !o_clk_out_en && !$past(o_clk_out_en) && !$past(o_clk_out_en, 2); endsequence
   property p_wake; i_wake_flag |-> ##[1:2] s_en_on; endproperty
   a_wake: assert property (p_wake) else $error("enables not forced by wake");
   property p_bchk; i_check_bit_count_ok && i_opm[1] |-> ##[1:2] s_en_on; endproperty
   a_bchk: assert property (p_bchk) else $error("enables not forced by check");
   property p_ckoff; s_off3 |-> !o_clk_out; endproperty
   a_ckoff: assert property (p_ckoff) else $error("clock out while disabled");
   property p_coarse; o_coarse_freq_term[6:0] == 7'h00; endproperty
   a_coarse: assert property (p_coarse) else $error("coarse term off step");
   property p_sleep; o_sleep_dclk[9:0] == 10'h000; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not in 1024 units");
   property p_limf; o_limit_factor inside {2'h1, 2'h2}; endproperty
   a_limf: assert property (p_limf) else $error("bad limit factor");
   property p_nchk; o_check_bit_count inside {4'h0, 4'h3, 4'h6, 4'h9}; endproperty
   a_nchk: assert property (p_nchk) else $error("bad bit count");
   property p_ext; o_ext_data_clock_period inside {5'h1, 5'h2, 5'h4, 5'h8, 5'h10}; endproperty
   a_ext: assert property (p_ext) else $error("bad extended period");
   property p_txh;
      $stable(o_min_edge_dclk) && $stable(o_ext_data_clock_period) && $stable(o_tx_half_bit_dclk)
      |-> o_tx_half_bit_dclk == o_min_edge_dclk + o_ext_data_clock_period;
   endproperty
   a_txh: assert property (p_txh) else $error("half bit not one period over min edge");
endmodule
bind xcr_cfg_regs xcr_cfg_regs_asserts u_xcr_cfg_regs_asserts (.i_mclk(i_mclk),
   .i_rst_b(i_rst_b), .i_opm(i_opm), .i_check_bit_count_ok(i_check_bit_count_ok), .i_wake_flag(i_wake_flag),
   .o_ext_supply_enable(o_ext_supply_enable), .o_clk_out_en(o_clk_out_en),
   .o_clk_out(o_clk_out), .o_coarse_freq_term(o_coarse_freq_term),
   .o_sleep_dclk(o_sleep_dclk), .o_limit_factor(o_limit_factor),
   .o_check_bit_count(o_check_bit_count), .o_ext_data_clock_period(o_ext_data_clock_period),
   .o_min_edge_dclk(o_min_edge_dclk), .o_tx_half_bit_dclk(o_tx_half_bit_dclk));
`default_nettype wire

// File: tb_xcr_cfg_regs.sv
// Testbench for the config registers 3 to 5.
`timescale 1ns/1ns
`default_nettype none
`include "xcr_regs.vh"
module tb_xcr_cfg_regs;
   logic mclk = 1'b0, rst_b = 1'b0, aux = 1'b0, wr, rd, bok = 1'b0, wfl = 1'b0, rin = 1'b0;
   logic sup, cken, ckout, mods;
   logic [1:0] opm = 2'h0, baud = 2'h2, limf;
   logic [3:0] adr, nchk;
   logic [4:0] keys = 5'h1f, extp;
   logic [6:0] fine = 7'h58;
   logic [7:0] wd, rdat, rv;
   logic [7:0] m [2:4];
   logic [8:0] crs, tune;
   logic [9:0] mine;
   logic [10:0] txh;
   logic [17:0] slp;
   int errors = 0, tests_run = 0;
   always #5 mclk = ~mclk;
   xcr_host_model u_xcr_host_model (.i_mclk(mclk), .i_aux(aux), .i_rdata(rdat),
      .o_wr_en(wr), .o_rd_en(rd), .o_addr(adr), .o_wdata(wd));
   xcr_cfg_regs u_xcr_cfg_regs (.i_mclk(mclk), .i_rst_b(rst_b), .i_wr_en(wr), .i_rd_en(rd),
      .i_addr(adr), .i_wdata(wd), .o_rdata(rdat), .i_opm(opm), .i_check_bit_count_ok(bok),
      .i_wake_flag(wfl), .i_wake_reinit(rin), .i_key_input_b(keys), .i_fine_freq_term(fine),
      .i_baud_range_select(baud), .o_ext_supply_enable(sup), .o_clk_out_en(cken),
      .o_clk_out(ckout), .o_coarse_freq_term(crs), .o_tune_word(tune),
      .o_modulation_select(mods), .o_sleep_dclk(slp), .o_limit_factor(limf),
      .o_check_bit_count(nchk), .o_ext_data_clock_period(extp), .o_min_edge_dclk(mine),
      .o_tx_half_bit_dclk(txh));
   task automatic report_and_stop;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s exp %h seen %h", n, e, s);
      end
   endtask
   function automatic logic [4:0] ext_p(input logic [1:0] b, input logic x);
      return (5'h08 >> b) << x;
   endfunction
   task automatic put(input logic [3:0] a, input logic [7:0] d);
      u_xcr_host_model.wr(a, d);
      if (a == 4'h2) m[2] = (aux ? (d | 8'h02) : d) & `XCR_RF_COARSE_MASK;
      else if (a == 4'h3 || a == 4'h4) m[a] = d;
   endtask
   task automatic get(input logic [3:0] a);
      u_xcr_host_model.rd(a, rv);
      chk("rdata", rv, (a >= 4'h2 && a <= 4'h4) ? m[a] : 8'h00);
   endtask
   task automatic chk_out;
      logic [4:0] e;
      repeat (2) @(posedge mclk);
      #1;
      e = ext_p(baud, m[3][0]);
      chk("coarse", crs, {m[2][3:2], 7'h00});
      chk("supply", sup, m[2][1]);
      chk("clk_en", cken, m[2][0]);
      chk("modsel", mods, m[3][7]);
      chk("sleep", slp, {3'h0, m[3][6:2], 10'h000} << (m[3][1] ? 3 : 0));
      chk("limf", limf, m[3][0] ? 2'h2 : 2'h1);
      chk("nchk", nchk, 4'(m[4][7:6]) * 4'h3);
      chk("extp", extp, e);
      chk("minedge", mine, m[4][5:0] * e);
      chk("txhalf", txh, (m[4][5:0] + 1) * e);
      chk("tune", tune, {m[2][3:2], 7'h00} + fine);
   endtask
   initial begin
      void'($urandom(53));
      m[2] = `XCR_RST_RF_COARSE;
      m[3] = `XCR_RST_MOD_SLEEP;
      m[4] = `XCR_RST_CHECK_BIT_COUNT_LIM;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      chk_out;
      for (int a = 0; a < 16; a++) get(a[3:0]);
      for (int c = 0; c < 4; c++) begin
         put(4'h2, {4'h0, c[1:0], 2'h3});
         put(4'h4, {c[1:0], 6'h0a});
         chk_out;
      end
      repeat (40) begin
         @(posedge mclk);
         fine <= 7'($urandom);
         baud <= 2'($urandom);
         aux <= 1'($urandom);
         put(4'($urandom), 8'($urandom));
         chk_out;
         get(4'h2 + 4'($urandom % 3));
      end
      aux <= 1'b0;
      for (int s = 0; s < 4; s++) begin
         put(4'h2, 8'h00);
         chk_out;
         opm <= (s == 3) ? 2'h1 : 2'h3;
         {bok, wfl} <= (s == 0 || s == 3) ? 2'b10 : (s == 1) ? 2'b01 : 2'b00;
         if (s == 2) keys <= 5'h1e;
         @(posedge mclk);
         {bok, wfl} <= 2'b00;
         keys <= 5'h1f;
         repeat (6) @(posedge mclk);
         if (s < 3) m[2][1:0] = 2'h3;
         get(4'h2);
      end
      put(4'h3, 8'h81);
      chk_out;
      @(posedge mclk);
      rin <= 1'b1;
      @(posedge mclk);
      rin <= 1'b0;
      m[2] = `XCR_RST_RF_COARSE;
      m[3] = `XCR_RST_MOD_SLEEP;
      m[4] = `XCR_RST_CHECK_BIT_COUNT_LIM;
      chk_out;
      get(4'h3);
      report_and_stop;
   end
   initial begin
      #100000;
      errors++;
      report_and_stop;
   end
endmodule
`default_nettype wire
